// File: rtl/vc2_tps_cfg.svh
// constants of the vc-2 1+1 bi-directional trail protection switch
// assumes a 250 MHz aclk and a 32-bit axi4-lite register port
// Summary of operation
// - selector picks working or protection for output
// - bridge copies normal input to both paths
// - config changes never disturb idle traffic
// - wait-to-restore set between five and twelve minutes
// - hold-off zero to ten seconds, 100 ms steps
// - revertive: barring, forced, manual to protection, clear
// - non-revertive: forced, manual per path, trial keeps selection, clear
// - fail and degrade per path, high priority
// - 1+1 bi-directional, aps on protection path only
// - termination source passes stream unchanged
// - trail fail forwarded; cause gated by enable
// - both paths down reports protected trail fail
// - aps multiplexed with data toward path layer
// - aps inserted only on the protection path
// - adaptation sink recovers data, clock, frame start
// - aps extracted with persistency, protection path only
`ifndef VC2_TPS_CFG_SVH
`define VC2_TPS_CFG_SVH
`define CLK_PERIOD_NS 4
`define HOLD_STEP_MS 100
`define HOLD_STEP_CYCLES ((`HOLD_STEP_MS * 1000000) / `CLK_PERIOD_NS)
`define HOLD_MAX_STEPS 7'h64
`define WTR_MIN_MINUTES 4'h5
`define WTR_MAX_MINUTES 4'hc
`define WTR_STEPS_PER_MIN 13'h258
`define SWITCH_TIME_MS 50
`define APS_PERSIST 2'h3
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STATUS 8'h0c
`define REG_IRQ_MASK 8'h10
`define CTRL_REVERTIVE 0
`define CTRL_REPORT 1
`define CTRL_WTR_LSB 8
`define CTRL_HO_LSB 16
`define CTRL_RESET 32'h0000_0503
`define CTRL_MASK 32'h007f_0f03
`define CMD_PATH 4
`define IRQ_SWITCH 0
`define IRQ_TRAIL_FAIL 1
`define IRQ_APS 2
`define IRQ_REJECT 3
`define IRQ_WIDTH 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/vc2_tps_pkg.sv
// types of the vc-2 1+1 bi-directional trail protection switch
// assumes nothing of its surroundings
`default_nettype none
package vc2_tps_pkg;
  // one stream item: data byte, frame start, frame clock strobe
  typedef struct packed {
    logic [7:0] data;
    logic fs;
    logic ck;
  } vc_stream_t;
  typedef enum logic [2:0] {
    clear_cmd = 3'b000,
    protection_barring_cmd = 3'b001,
    forced_switch_cmd = 3'b010,
    manual_switch_cmd = 3'b011,
    trial_run_cmd = 3'b100
  } ext_cmd_t;
  // ordered by priority, highest code wins
  typedef enum logic [3:0] {
    req_none = 4'h0,
    req_trial = 4'h1,
    req_wtr = 4'h2,
    req_manual = 4'h3,
    req_degrade = 4'h4,
    req_fail_work = 4'h5,
    req_forced = 4'h6,
    req_fail_prot = 4'h7,
    req_barring = 4'h8
  } req_t;
  typedef struct packed {
    req_t req;
    logic path;
  } aps_t;
endpackage : vc2_tps_pkg
`default_nettype wire

// File: rtl/vc2_trail_protection_switch.sv
// vc-2 1+1 bi-directional trail protection: bridge, selector, termination, adaptation
// assumes streams and aps are synchronous to aclk; ck marks a frame clock tick
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "vc2_tps_cfg.svh"
`default_nettype none
module vc2_trail_protection_switch #(
  parameter int unsigned STEP_CYCLES = `HOLD_STEP_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // normal side
  input wire vc2_tps_pkg::vc_stream_t normal_in,
  output var vc2_tps_pkg::vc_stream_t normal_out,
  output var logic normal_server_fail,
  // path layer access points, index 0 working, 1 protection
  output var vc2_tps_pkg::vc_stream_t working_out,
  output var vc2_tps_pkg::vc_stream_t protection_out,
  output var vc2_tps_pkg::aps_t protection_switch_signal_out,
  input wire vc2_tps_pkg::vc_stream_t working_in,
  input wire vc2_tps_pkg::vc_stream_t protection_in,
  input wire vc2_tps_pkg::aps_t protection_switch_signal_in,
  input wire logic [1:0] access_trail_signal_fail,
  input wire logic [1:0] access_trail_signal_degrade,
  // protected trail status and interrupt
  output var logic trail_fail_action,
  output var logic reported_server_fail_cause,
  output var logic irq
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  function automatic logic cmd_ok(input logic [2:0] code, input logic path, input logic rev);
    logic ok;
    ok = 1'b0;
    unique case (code)
      3'b000, 3'b001: ok = 1'b1;
      3'b010, 3'b011: ok = rev ? path : 1'b1;
      3'b100: ok = !rev;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_ok

  // register state
  logic [31:0] ctrl;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  vc2_tps_pkg::ext_cmd_t active_cmd;
  logic cmd_path;
  logic cmd_reject;

  // axi write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic do_read;
  logic rd_clear;

  // protection state
  logic [1:0] server_fail_action;
  logic [1:0] server_degrade_action;
  logic [24:0] step_cnt;
  logic step_tick;
  logic [6:0] ho_cnt [2];
  logic [12:0] wtr_cnt;
  logic sel;
  vc2_tps_pkg::req_t local_req;
  vc2_tps_pkg::aps_t remote_aps;
  vc2_tps_pkg::aps_t aps_cand;
  logic [1:0] aps_rep;
  logic aps_event;
  vc2_tps_pkg::req_t next_req;
  logic next_path;
  logic next_sel;
  logic next_trail_fail;

  // configuration decode, clamped to the supported ranges
  logic revertive;
  logic [3:0] wtr_min;
  logic [6:0] ho_steps;
  logic [12:0] wtr_limit;
  logic [1:0] sf_eff;
  logic [1:0] sd_eff;

  assign revertive = ctrl[`CTRL_REVERTIVE];
  assign wtr_min = (ctrl[`CTRL_WTR_LSB +: 4] < `WTR_MIN_MINUTES) ? `WTR_MIN_MINUTES :
                   (ctrl[`CTRL_WTR_LSB +: 4] > `WTR_MAX_MINUTES) ? `WTR_MAX_MINUTES :
                   ctrl[`CTRL_WTR_LSB +: 4];
  assign ho_steps = (ctrl[`CTRL_HO_LSB +: 7] > `HOLD_MAX_STEPS) ? `HOLD_MAX_STEPS :
                    ctrl[`CTRL_HO_LSB +: 7];
  assign wtr_limit = 13'(13'(wtr_min) * `WTR_STEPS_PER_MIN);

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_clear = do_read && (s_axi_araddr == `REG_IRQ_STATUS);

  // write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (wr_addr)
          `REG_CTRL, `REG_CMD, `REG_STATUS, `REG_IRQ_STATUS, `REG_IRQ_MASK: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        unique case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= ctrl;
          `REG_CMD: s_axi_rdata <= {27'h0, cmd_path, 1'b0, active_cmd};
          `REG_STATUS: begin
            s_axi_rdata <= {4'h0, remote_aps.req, 6'h0, reported_server_fail_cause,
                            trail_fail_action, server_degrade_action, server_fail_action,
                            3'h0, remote_aps.path, local_req, 3'h0, sel};
          end
          `REG_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
          `REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // configuration; only timers, priorities, command checks and the cause report read it, never the data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTRL_RESET;
      irq_mask <= 4'h0;
    end else if (do_write) begin
      if (wr_addr == `REG_CTRL) begin
        ctrl <= strb_merge(ctrl, wr_data, wr_strb) & `CTRL_MASK;
      end
      if (wr_addr == `REG_IRQ_MASK) begin
        irq_mask <= 4'(strb_merge({28'h0, irq_mask}, wr_data, wr_strb));
      end
    end
  end

  // external commands, checked against the operation type
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_cmd <= vc2_tps_pkg::clear_cmd;
      cmd_path <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= 1'b0;
      if (do_write && wr_addr == `REG_CMD && wr_strb[0]) begin
        if (cmd_ok(wr_data[2:0], wr_data[`CMD_PATH], revertive)) begin
          active_cmd <= vc2_tps_pkg::ext_cmd_t'(wr_data[2:0]);
          cmd_path <= wr_data[`CMD_PATH];
        end else begin
          cmd_reject <= 1'b1;
        end
      end else if (revertive && active_cmd == vc2_tps_pkg::trial_run_cmd) begin
        active_cmd <= vc2_tps_pkg::clear_cmd;
      end
    end
  end

  // adaptation sink: access trail conditions become server conditions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      server_fail_action <= 2'b00;
      server_degrade_action <= 2'b00;
    end else begin
      server_fail_action <= access_trail_signal_fail;
      server_degrade_action <= access_trail_signal_degrade;
    end
  end

  // 100 ms step for hold-off and wait-to-restore
  assign step_tick = (step_cnt == 25'(STEP_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt <= 25'h0;
    end else begin
      step_cnt <= step_tick ? 25'h0 : step_cnt + 25'h1;
    end
  end

  // hold-off per path before a new condition counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ho_cnt[0] <= 7'h00;
      ho_cnt[1] <= 7'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!(server_fail_action[i] || server_degrade_action[i])) begin
          ho_cnt[i] <= 7'h00;
        end else if (step_tick && ho_cnt[i] < ho_steps) begin
          ho_cnt[i] <= ho_cnt[i] + 7'h01;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sf_eff[i] = server_fail_action[i] && (ho_cnt[i] >= ho_steps);
      sd_eff[i] = server_degrade_action[i] && (ho_cnt[i] >= ho_steps);
    end
  end

  // local request, highest priority first
  always_comb begin
    next_req = vc2_tps_pkg::req_none;
    next_path = sel;
    if (active_cmd == vc2_tps_pkg::protection_barring_cmd) begin
      next_req = vc2_tps_pkg::req_barring;
      next_path = 1'b0;
    end else if (sf_eff[1]) begin
      next_req = vc2_tps_pkg::req_fail_prot;
      next_path = 1'b0;
    end else if (active_cmd == vc2_tps_pkg::forced_switch_cmd) begin
      next_req = vc2_tps_pkg::req_forced;
      next_path = cmd_path;
    end else if (sf_eff[0]) begin
      next_req = vc2_tps_pkg::req_fail_work;
      next_path = 1'b1;
    end else if (sd_eff[0] != sd_eff[1]) begin
      next_req = vc2_tps_pkg::req_degrade;
      next_path = sd_eff[0];
    end else if (active_cmd == vc2_tps_pkg::manual_switch_cmd) begin
      next_req = vc2_tps_pkg::req_manual;
      next_path = cmd_path;
    end else if (revertive && sel) begin
      next_req = (wtr_cnt >= wtr_limit) ? vc2_tps_pkg::req_none : vc2_tps_pkg::req_wtr;
      next_path = (wtr_cnt < wtr_limit);
    end else if (active_cmd == vc2_tps_pkg::trial_run_cmd) begin
      next_req = vc2_tps_pkg::req_trial;
      next_path = sel;
    end
  end

  // a stronger far-end request steers both ends the same way
  assign next_sel = (remote_aps.req > next_req) ? remote_aps.path : next_path;
  assign next_trail_fail = (next_sel ? server_fail_action[1] : server_fail_action[0]) ||
                           (&server_fail_action);

  // wait-to-restore runs only while waiting to go back to working
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wtr_cnt <= 13'h0;
    end else if (next_req != vc2_tps_pkg::req_wtr) begin
      wtr_cnt <= 13'h0;
    end else if (step_tick && wtr_cnt < wtr_limit) begin
      wtr_cnt <= wtr_cnt + 13'h1;
    end
  end

  // selector state, acted on one cycle after the condition is effective
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel <= 1'b0;
      local_req <= vc2_tps_pkg::req_none;
    end else begin
      sel <= next_sel;
      local_req <= next_req;
    end
  end

  // far-end aps, protection path only, accepted after repeated frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_aps <= '{req: vc2_tps_pkg::req_none, path: 1'b0};
      aps_cand <= '{req: vc2_tps_pkg::req_none, path: 1'b0};
      aps_rep <= 2'h0;
      aps_event <= 1'b0;
    end else begin
      aps_event <= 1'b0;
      if (protection_in.fs && protection_in.ck) begin
        if (protection_switch_signal_in != aps_cand) begin
          aps_cand <= protection_switch_signal_in;
          aps_rep <= 2'h1;
        end else if (aps_rep < `APS_PERSIST) begin
          aps_rep <= aps_rep + 2'h1;
          if (aps_rep + 2'h1 == `APS_PERSIST && aps_cand != remote_aps) begin
            remote_aps <= aps_cand;
            aps_event <= 1'b1;
          end
        end
      end
    end
  end

  // bridge, selector output and adaptation source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_out <= '0;
      protection_out <= '0;
      normal_out <= '0;
      protection_switch_signal_out <= '{req: vc2_tps_pkg::req_none, path: 1'b0};
    end else begin
      working_out <= normal_in;
      protection_out <= normal_in;
      protection_switch_signal_out <= '{req: next_req, path: next_sel};
      normal_out <= next_sel ? protection_in : working_in;
    end
  end

  // protection trail termination sink
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trail_fail_action <= 1'b0;
      normal_server_fail <= 1'b0;
      reported_server_fail_cause <= 1'b0;
    end else begin
      trail_fail_action <= next_trail_fail;
      normal_server_fail <= next_trail_fail;
      reported_server_fail_cause <= next_trail_fail && ctrl[`CTRL_REPORT];
    end
  end

  // sticky events, set wins over the clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (rd_clear ? 4'h0 : irq_status) |
                    {cmd_reject, aps_event, next_trail_fail && !trail_fail_action,
                     next_sel != sel};
      irq <= |(((rd_clear ? 4'h0 : irq_status) |
                {cmd_reject, aps_event, next_trail_fail && !trail_fail_action,
                 next_sel != sel}) & irq_mask);
    end
  end

endmodule : vc2_trail_protection_switch
`default_nettype wire

// File: tb/tb_vc2_trail_protection_switch.sv
// self-checking bench of the vc-2 trail protection switch
// assumes the far-end model and the port checker are compiled with it
`include "vc2_tps_cfg.svh"
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_vc2_trail_protection_switch;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, access_trail_signal_fail, access_trail_signal_degrade;
  logic normal_server_fail, trail_fail_action, reported_server_fail_cause, irq;
  vc2_tps_pkg::vc_stream_t normal_in, normal_out, working_out, protection_out;
  vc2_tps_pkg::vc_stream_t working_in, protection_in;
  vc2_tps_pkg::aps_t protection_switch_signal_out, protection_switch_signal_in, far_aps;
  int n_errors, n_compared;
  logic [13:0] rows [15];
  logic [13:0] r;
  logic [7:0] bad [3] = '{8'h04, 8'h02, 8'h03};
  logic [7:0] rcmd [2] = '{8'h12, 8'h13};
  wire logic pth = protection_switch_signal_out.path;
  vc2_trail_protection_switch #(.STEP_CYCLES(10)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .normal_in, .normal_out,
    .normal_server_fail, .working_out, .protection_out, .protection_switch_signal_out,
    .working_in, .protection_in, .protection_switch_signal_in, .access_trail_signal_fail,
    .access_trail_signal_degrade, .trail_fail_action, .reported_server_fail_cause, .irq);
  vc2_far_end_model u_far (.aclk, .aresetn, .far_aps, .working_in, .protection_in,
    .aps_in(protection_switch_signal_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    normal_in.data <= normal_in.data + 8'h05;
    normal_in.ck <= ~normal_in.ck;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic lines(input logic [1:0] f, input logic [1:0] d);
    @(posedge aclk);
    access_trail_signal_fail <= f;
    access_trail_signal_degrade <= d;
  endtask : lines
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    summarize();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {access_trail_signal_fail, access_trail_signal_degrade} = '0;
    normal_in = '0;
    far_aps = '0;
    aresetn = 1'b0;
    n_errors = 0;
    n_compared = 0;
    // {fail, degrade, command or ff for none, path, trail fail}
    rows = '{{2'b00, 2'b00, 8'hff, 2'b00}, {2'b01, 2'b00, 8'hff, 2'b10},
      {2'b00, 2'b00, 8'hff, 2'b10}, {2'b10, 2'b00, 8'hff, 2'b00}, {2'b00, 2'b00, 8'h13, 2'b10},
      {2'b00, 2'b00, 8'h03, 2'b00}, {2'b00, 2'b00, 8'h12, 2'b10}, {2'b01, 2'b00, 8'hff, 2'b10},
      {2'b01, 2'b00, 8'h02, 2'b01}, {2'b00, 2'b00, 8'h01, 2'b00}, {2'b11, 2'b00, 8'h00, 2'b01},
      {2'b00, 2'b01, 8'hff, 2'b10}, {2'b00, 2'b10, 8'hff, 2'b00}, {2'b00, 2'b00, 8'h14, 2'b00},
      {2'b00, 2'b00, 8'h04, 2'b00}};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`REG_CTRL);
    `CHK(rd, `CTRL_RESET)
    rdr(8'h40);
    `CHK(rs, `RESP_SLVERR)
    // refused commands in revertive mode raise the masked interrupt
    wr(`REG_CMD, 32'h0000_0004);
    cyc(4);
    `CHK(irq, 1'b0)
    rdr(`REG_IRQ_STATUS);
    `CHK(rd[3], 1'b1)
    wr(`REG_IRQ_MASK, 32'h0000_0008);
    foreach (bad[i]) begin
      wr(`REG_CMD, {24'h000000, bad[i]});
      cyc(3);
      `CHK(irq, 1'b1)
      rdr(`REG_IRQ_STATUS);
      `CHK(rd[3], 1'b1)
      cyc(2);
      `CHK(irq, 1'b0)
    end
    // configuration changes with nothing requested
    wr(`REG_CTRL, 32'h0001_0c02);
    wr(`REG_CTRL, `CTRL_RESET);
    rdr(`REG_IRQ_STATUS);
    `CHK(rd[0], 1'b0)
    foreach (rcmd[i]) begin
      wr(`REG_CMD, {24'h000000, rcmd[i]});
      cyc(40);
      `CHK(pth, 1'b1)
      wr(`REG_CMD, 32'h0000_0001);
      cyc(40);
      `CHK(pth, 1'b0)
    end
    lines(2'b01, 2'b00);
    cyc(40);
    `CHK(pth, 1'b0)
    wr(`REG_CMD, 32'h0000_0000);
    cyc(40);
    `CHK(pth, 1'b1)
    lines(2'b00, 2'b00);
    cyc(29900);
    `CHK(pth, 1'b1)
    cyc(300);
    `CHK(pth, 1'b0)
    wr(`REG_CTRL, 32'h0000_0502);
    foreach (rows[i]) begin
      r = rows[i];
      lines(r[13:12], r[11:10]);
      if (r[9:2] != 8'hff) wr(`REG_CMD, {24'h000000, r[9:2]});
      cyc(40);
      rdr(`REG_STATUS);
      `CHK(rd[0], r[1])
      `CHK(pth, r[1])
      `CHK(rd[16], r[0])
      `CHK(trail_fail_action, r[0])
      `CHK(normal_server_fail, r[0])
      `CHK(rd[15:12], {r[11:10], r[13:12]})
      `CHK(irq, 1'b0)
    end
    wr(`REG_CTRL, 32'h0002_0502);
    lines(2'b01, 2'b00);
    cyc(6);
    `CHK(pth, 1'b0)
    cyc(30);
    `CHK(pth, 1'b1)
    wr(`REG_CTRL, 32'h0000_0500);
    lines(2'b11, 2'b00);
    cyc(10);
    `CHK(trail_fail_action, 1'b1)
    `CHK(reported_server_fail_cause, 1'b0)
    wr(`REG_CTRL, 32'h0000_0502);
    cyc(4);
    `CHK(reported_server_fail_cause, 1'b1)
    lines(2'b00, 2'b00);
    wr(`REG_CMD, 32'h0000_0003);
    cyc(40);
    `CHK(pth, 1'b0)
    `CHK(protection_switch_signal_out.req, vc2_tps_pkg::req_manual)
    far_aps <= '{req: vc2_tps_pkg::req_forced, path: 1'b1};
    cyc(300);
    rdr(`REG_STATUS);
    `CHK(rd[27:24], vc2_tps_pkg::req_forced)
    `CHK(pth, 1'b1)
    summarize();
  end
endmodule : tb_vc2_trail_protection_switch
`default_nettype wire

// File: tb/vc2_far_end_model.sv
// far-end path layer model feeding both access points of the switch
// assumes aclk and the synchronous active-low aresetn of the switch
`default_nettype none
module vc2_far_end_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request signalled by the far end
  input wire vc2_tps_pkg::aps_t far_aps,
  // streams and aps toward the switch
  output var vc2_tps_pkg::vc_stream_t working_in,
  output var vc2_tps_pkg::vc_stream_t protection_in,
  output var vc2_tps_pkg::aps_t aps_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // frame timing: ck every fourth cycle, fs every 64
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  // distinct payload per path so the selection shows
  always_comb begin
    working_in = '{data: cnt, fs: cnt[5:0] == 6'h00, ck: cnt[1:0] == 2'h0};
    protection_in = '{data: ~cnt, fs: cnt[5:0] == 6'h00, ck: cnt[1:0] == 2'h0};
  end
  // aps rides the protection path only, changed at frame start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aps_in <= '0;
    end else if (protection_in.fs && protection_in.ck) begin
      aps_in <= far_aps;
    end
  end
endmodule : vc2_far_end_model
`default_nettype wire

// File: tb/vc2_tps_asserts.sv
// port checker of the vc-2 trail protection switch
// assumes one aclk domain; bound to the top module after the checker
`default_nettype none
module vc2_tps_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // streams
  input wire vc2_tps_pkg::vc_stream_t normal_in,
  input wire vc2_tps_pkg::vc_stream_t normal_out,
  input wire vc2_tps_pkg::vc_stream_t working_out,
  input wire vc2_tps_pkg::vc_stream_t protection_out,
  input wire vc2_tps_pkg::vc_stream_t working_in,
  input wire vc2_tps_pkg::vc_stream_t protection_in,
  // protection state
  input wire vc2_tps_pkg::aps_t protection_switch_signal_out,
  input wire vc2_tps_pkg::aps_t protection_switch_signal_in,
  input wire logic [1:0] access_trail_signal_fail,
  input wire logic trail_fail_action,
  input wire logic reported_server_fail_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wf;
  // working fail alone, with nothing stronger asked at either end
  assign wf = access_trail_signal_fail == 2'b01
    && protection_switch_signal_out.req < vc2_tps_pkg::req_forced
    && protection_switch_signal_in.req < vc2_tps_pkg::req_forced;
  AST_BRIDGE_WORK: assert property ($past(aresetn) |-> working_out == $past(normal_in))
    else $error("working output is not the delayed normal input");
  AST_BRIDGE_PROT: assert property ($past(aresetn) |-> protection_out == $past(normal_in))
    else $error("protection output is not the delayed normal input");
  AST_SEL_WORK: assert property ((!protection_switch_signal_out.path)[*3]
    |-> normal_out == $past(working_in)) else $error("normal output not from working path");
  AST_SEL_PROT: assert property ((protection_switch_signal_out.path)[*3]
    |-> normal_out == $past(protection_in)) else $error("normal output not from protection");
  AST_FAIL_SWITCH: assert property ($rose(wf)
    |-> ##[1:30] (protection_switch_signal_out.path || !wf)) else $error("no switch on fail");
  AST_BOTH_FAIL: assert property ($rose(&access_trail_signal_fail)
    ##1 (&access_trail_signal_fail)[*3] |-> trail_fail_action) else $error("trail fail missing");
  AST_CAUSE: assert property (reported_server_fail_cause
    |-> trail_fail_action || $past(trail_fail_action)) else $error("cause without trail fail");
  AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  COV_SWITCH: cover property ($rose(protection_switch_signal_out.path));
  COV_TRAIL: cover property ($rose(trail_fail_action));
  COV_FAIL: cover property ($rose(wf));
endmodule : vc2_tps_asserts
bind vc2_trail_protection_switch vc2_tps_asserts u_asserts (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .normal_in, .normal_out, .working_out, .protection_out, .working_in,
  .protection_in, .protection_switch_signal_out, .protection_switch_signal_in,
  .access_trail_signal_fail, .trail_fail_action, .reported_server_fail_cause);
`default_nettype wire
